// [rtl/cto_pkg.sv]
`default_nettype none

package cto_pkg;

	// Timing base and widths.
	localparam int MCLK_MHZ = 100;
	localparam int TIME_W = 20;
	localparam int WDOG_W = 24;
	localparam int DCNT_W = 8;
	localparam int ADDR_W = 8;

	// Divided control pulse width and the reset hold demanded of the system.
	localparam int DIV_PULSE_NS = 1000;
	localparam int RESET_HOLD_NS = 50;
	localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * MCLK_MHZ + 999) / 1000;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CYCLE_POS = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_CON_START = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_CON_WIDTH = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_DIV_START = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_DIV_PERIOD = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_DIV_COUNT = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_WDOG_LOAD = 8'h1C;
	localparam logic [ADDR_W-1:0] ADDR_WDOG_KICK = 8'h20;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h24;
	localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h28;
	localparam logic [ADDR_W-1:0] ADDR_WDOG_COUNT = 8'h2C;

	// Control register layout, bit 6 first.
	localparam int CTRL_W = 7;
	typedef struct packed {
		logic div_every_n;
		logic fault_hold;
		logic fault_en;
		logic serial_compat;
		logic div_pol;
		logic con_pol;
		logic cyc_pol;
	} cto_ctrl_t;

	// Status and mask bit positions.
	localparam int ST_CYCLE = 0;
	localparam int ST_CON = 1;
	localparam int ST_FAULT = 2;
	localparam int ST_WDOG = 3;
	localparam int ST_DIV = 4;
	localparam int ST_W = 5;

	// Synchronised pin vector positions.
	localparam int PIN_CYC = 0;
	localparam int PIN_SCLK = 1;
	localparam int PIN_DIST = 2;
	localparam int PIN_LOSS = 3;
	localparam int PIN_OD = 4;
	localparam int PIN_NAND = 5;

	// Reset values.
	localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
	localparam logic [TIME_W-1:0] TIME_RST = 20'h00000;
	localparam logic [DCNT_W-1:0] DCNT_RST = 8'h00;
	localparam logic [WDOG_W-1:0] WDOG_LOAD_RST = 24'hFFFFFF;
	localparam logic [ST_W-1:0] MASK_RST = 5'h00;

	typedef enum logic [1:0] {
		DIV_IDLE,
		DIV_WAIT,
		DIV_HIGH,
		DIV_GAP
	} cto_div_state_t;

endpackage

`default_nettype wire

// [rtl/cto_div_pulse.sv]
`default_nettype none

module cto_div_pulse
	import cto_pkg::*;
#(
	parameter int CLK_MHZ = MCLK_MHZ
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clear,
	input wire logic cycle_start,
	input wire logic every_n,
	input wire logic polarity,
	input wire logic [TIME_W-1:0] start_delay,
	input wire logic [TIME_W-1:0] period,
	input wire logic [DCNT_W-1:0] count,
	output logic pulse_out,
	output logic pulse_begin
);

	// Width in master clock cycles follows the configured clock rate.
	localparam int PULSE_CYC_RAW = (DIV_PULSE_NS * CLK_MHZ) / 1000;
	localparam int PULSE_CYC = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
	localparam logic [TIME_W-1:0] PULSE_LAST = TIME_W'(PULSE_CYC - 1);

	cto_div_state_t state;
	logic [TIME_W-1:0] timer;
	logic [DCNT_W-1:0] left;
	logic [DCNT_W-1:0] rep;
	logic in_high;

	// A counted cycle start resynchronises the train; in every-N mode the skipped starts leave a late train running.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state <= DIV_IDLE;
			timer <= TIME_RST;
			left <= DCNT_RST;
			rep <= DCNT_RST;
		end
		else if (clear)
		begin
			state <= DIV_IDLE;
			timer <= TIME_RST;
			left <= DCNT_RST;
			rep <= DCNT_RST;
		end
		else if (cycle_start && count != DCNT_RST)
		begin
			if (!every_n)
			begin
				state <= DIV_WAIT;
				timer <= start_delay;
				left <= count;
			end
			else if (rep >= count - DCNT_W'(1))
			begin
				rep <= DCNT_RST;
				state <= DIV_WAIT;
				timer <= start_delay;
				left <= DCNT_W'(1);
			end
			else
			begin
				rep <= rep + DCNT_W'(1);
			end
		end
		else
		begin
			unique case (state)
				DIV_IDLE:
				begin
					timer <= TIME_RST;
				end
				DIV_WAIT, DIV_GAP:
				begin
					if (timer == TIME_RST)
					begin
						state <= DIV_HIGH;
						timer <= PULSE_LAST;
					end
					else
					begin
						timer <= timer - TIME_W'(1);
					end
				end
				DIV_HIGH:
				begin
					if (timer != TIME_RST)
					begin
						timer <= timer - TIME_W'(1);
					end
					else if (left <= DCNT_W'(1))
					begin
						state <= DIV_IDLE;
						left <= DCNT_RST;
					end
					else
					begin
						left <= left - DCNT_W'(1);
						state <= DIV_GAP;
						timer <= period;
					end
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			in_high <= 1'b0;
			pulse_out <= 1'b0;
			pulse_begin <= 1'b0;
		end
		else
		begin
			in_high <= (state == DIV_HIGH);
			pulse_out <= (state == DIV_HIGH) ^ polarity;
			pulse_begin <= (state == DIV_HIGH) && !in_high;
		end
	end

endmodule

`default_nettype wire

// [rtl/cto_cycle_timing.sv]
`default_nettype none

module cto_cycle_timing
	import cto_pkg::*;
#(
	parameter int NAND_W = 8,
	parameter int CLK_MHZ = MCLK_MHZ
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic cycle_sync_in,
	input wire logic serial_clk_in,
	input wire logic rx_distortion_in,
	input wire logic rx_signal_absent_in,
	input wire logic output_disable_in,
	input wire logic [NAND_W-1:0] nand_chain_in,
	output logic control_pulse_out,
	output logic divided_pulse_out,
	output logic serial_clock_half_out,
	output logic serial_clock_quarter_out,
	output logic line_fault_n,
	output logic watchdog_out_n,
	output logic pins_oe,
	output logic nand_chain_out,
	output logic irq
);

	localparam int PIN_W = PIN_NAND + NAND_W;

	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic od;
	logic take;
	logic wr_pend;
	logic rd_pend;
	logic [ADDR_W-1:0] acc_addr;
	logic [31:0] rd_mux;
	cto_ctrl_t ctrl;
	logic [TIME_W-1:0] con_start;
	logic [TIME_W-1:0] con_width;
	logic [TIME_W-1:0] div_start;
	logic [TIME_W-1:0] div_period;
	logic [DCNT_W-1:0] div_count;
	logic [WDOG_W-1:0] wdog_load;
	logic [ST_W-1:0] mask;
	logic [ST_W-1:0] status;
	logic [ST_W-1:0] events;
	logic [ST_W-1:0] w1c;
	logic [ST_W-1:0] next_status;
	logic cyc_s3;
	logic cycle_start;
	logic [TIME_W-1:0] cycle_pos;
	logic [TIME_W-1:0] con_cnt;
	logic [TIME_W-1:0] next_con_cnt;
	logic con_hit;
	logic sclk_s3;
	logic [1:0] sdiv;
	logic fault_raw;
	logic fault_prev;
	logic [WDOG_W-1:0] wdog_cnt;
	logic wdog_armed;
	logic kick;
	logic wdog_expire;
	logic div_begin;
	logic div_pulse;
	logic [NAND_W-1:0] nand_chain;

	// Every pin input, test chain included, is retimed before any logic looks at it.
	assign pin_raw = {nand_chain_in, output_disable_in, rx_signal_absent_in,
		rx_distortion_in, serial_clk_in, cycle_sync_in};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end
		else
		begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
		end
	end

	assign od = pin_s2[PIN_OD];

	// Bus slave: writes finish with no wait state, reads take one so they see the prior write.
	assign take = hsel && htrans[1] && hready;
	assign hreadyout = !rd_pend;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			acc_addr <= '0;
		end
		else
		begin
			wr_pend <= take && hwrite;
			rd_pend <= take && !hwrite;
			if (take)
			begin
				acc_addr <= haddr[ADDR_W-1:0];
			end
		end
	end

	always_comb
	begin
		rd_mux = 32'h00000000;
		unique case (acc_addr)
			ADDR_CTRL: rd_mux[CTRL_W-1:0] = ctrl;
			ADDR_CYCLE_POS: rd_mux[TIME_W-1:0] = cycle_pos;
			ADDR_CON_START: rd_mux[TIME_W-1:0] = con_start;
			ADDR_CON_WIDTH: rd_mux[TIME_W-1:0] = con_width;
			ADDR_DIV_START: rd_mux[TIME_W-1:0] = div_start;
			ADDR_DIV_PERIOD: rd_mux[TIME_W-1:0] = div_period;
			ADDR_DIV_COUNT: rd_mux[DCNT_W-1:0] = div_count;
			ADDR_WDOG_LOAD: rd_mux[WDOG_W-1:0] = wdog_load;
			ADDR_STATUS: rd_mux[ST_W-1:0] = status;
			ADDR_MASK: rd_mux[ST_W-1:0] = mask;
			ADDR_WDOG_COUNT: rd_mux[WDOG_W-1:0] = wdog_cnt;
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h00000000;
		end
		else if (rd_pend)
		begin
			hrdata <= rd_mux;
		end
	end

	// Output disable clears the configuration too, as all timing, fault, watchdog and status logic is held in reset.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl <= cto_ctrl_t'(CTRL_RST);
			con_start <= TIME_RST;
			con_width <= TIME_RST;
			div_start <= TIME_RST;
			div_period <= TIME_RST;
			div_count <= DCNT_RST;
			wdog_load <= WDOG_LOAD_RST;
			mask <= MASK_RST;
		end
		else if (od)
		begin
			ctrl <= cto_ctrl_t'(CTRL_RST);
			con_start <= TIME_RST;
			con_width <= TIME_RST;
			div_start <= TIME_RST;
			div_period <= TIME_RST;
			div_count <= DCNT_RST;
			wdog_load <= WDOG_LOAD_RST;
			mask <= MASK_RST;
		end
		else if (wr_pend)
		begin
			unique case (acc_addr)
				ADDR_CTRL: ctrl <= cto_ctrl_t'(hwdata[CTRL_W-1:0]);
				ADDR_CON_START: con_start <= hwdata[TIME_W-1:0];
				ADDR_CON_WIDTH: con_width <= hwdata[TIME_W-1:0];
				ADDR_DIV_START: div_start <= hwdata[TIME_W-1:0];
				ADDR_DIV_PERIOD: div_period <= hwdata[TIME_W-1:0];
				ADDR_DIV_COUNT: div_count <= hwdata[DCNT_W-1:0];
				ADDR_WDOG_LOAD: wdog_load <= hwdata[WDOG_W-1:0];
				ADDR_MASK: mask <= hwdata[ST_W-1:0];
				default: ;
			endcase
		end
	end

	// Cycle timing: the active edge of the sync input restarts the position counter.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cyc_s3 <= 1'b0;
			sclk_s3 <= 1'b0;
		end
		else
		begin
			cyc_s3 <= pin_s2[PIN_CYC];
			sclk_s3 <= pin_s2[PIN_SCLK];
		end
	end

	assign cycle_start = !od && ((pin_s2[PIN_CYC] ^ ctrl.cyc_pol) && !(cyc_s3 ^ ctrl.cyc_pol));

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cycle_pos <= '1;
		end
		else if (od)
		begin
			cycle_pos <= '1;
		end
		else if (cycle_start)
		begin
			cycle_pos <= TIME_RST;
		end
		else if (cycle_pos != '1)
		begin
			cycle_pos <= cycle_pos + TIME_W'(1);
		end
	end

	// The position saturates, so a stalled cycle clock cannot retrigger the control pulse.
	assign con_hit = (cycle_pos == con_start) && (cycle_pos != '1) && (con_width != TIME_RST);

	always_comb
	begin
		next_con_cnt = con_cnt;
		if (con_hit)
		begin
			next_con_cnt = con_width;
		end
		else if (con_cnt != TIME_RST)
		begin
			next_con_cnt = con_cnt - TIME_W'(1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			con_cnt <= TIME_RST;
			control_pulse_out <= 1'b0;
		end
		else if (od)
		begin
			con_cnt <= TIME_RST;
			control_pulse_out <= 1'b0;
		end
		else
		begin
			con_cnt <= next_con_cnt;
			control_pulse_out <= (next_con_cnt != TIME_RST) ^ ctrl.con_pol;
		end
	end

	cto_div_pulse #(
		.CLK_MHZ(CLK_MHZ)
	) i_cto_div_pulse (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear(od),
		.cycle_start(cycle_start),
		.every_n(ctrl.div_every_n),
		.polarity(ctrl.div_pol),
		.start_delay(div_start),
		.period(div_period),
		.count(div_count),
		.pulse_out(div_pulse),
		.pulse_begin(div_begin)
	);

	assign divided_pulse_out = div_pulse;

	// Serial clock division works on the retimed clock, so it is only valid well below hclk/2.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sdiv <= 2'h0;
			serial_clock_half_out <= 1'b0;
			serial_clock_quarter_out <= 1'b0;
		end
		else if (od)
		begin
			sdiv <= 2'h0;
			serial_clock_half_out <= 1'b0;
			serial_clock_quarter_out <= 1'b0;
		end
		else
		begin
			if (pin_s2[PIN_SCLK] && !sclk_s3)
			begin
				sdiv <= sdiv + 2'h1;
			end
			serial_clock_half_out <= ctrl.serial_compat ? pin_s2[PIN_SCLK] : sdiv[0];
			serial_clock_quarter_out <= ctrl.serial_compat ? sdiv[0] : sdiv[1];
		end
	end

	// Line fault either follows the receiver or holds until its status bit is cleared.
	assign fault_raw = ctrl.fault_en && (pin_s2[PIN_DIST] || pin_s2[PIN_LOSS]);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fault_prev <= 1'b0;
			line_fault_n <= 1'b1;
		end
		else if (od)
		begin
			fault_prev <= 1'b0;
			line_fault_n <= 1'b1;
		end
		else
		begin
			fault_prev <= fault_raw;
			line_fault_n <= !(fault_raw || (ctrl.fault_hold && status[ST_FAULT]));
		end
	end

	// Watchdog runs only after the first kick, so software may configure it first.
	assign kick = wr_pend && (acc_addr == ADDR_WDOG_KICK);
	assign wdog_expire = wdog_armed && !kick && (wdog_cnt == WDOG_W'(1));

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wdog_cnt <= '0;
			wdog_armed <= 1'b0;
			watchdog_out_n <= 1'b1;
		end
		else if (od)
		begin
			wdog_cnt <= '0;
			wdog_armed <= 1'b0;
			watchdog_out_n <= 1'b1;
		end
		else
		begin
			if (kick)
			begin
				wdog_cnt <= wdog_load;
				wdog_armed <= 1'b1;
			end
			else if (wdog_cnt != '0)
			begin
				wdog_cnt <= wdog_cnt - WDOG_W'(1);
			end
			watchdog_out_n <= !(wdog_armed && !kick && wdog_cnt <= WDOG_W'(1));
		end
	end

	// Interrupt status: a new event wins over a write-one-to-clear in the same cycle.
	always_comb
	begin
		events = '0;
		events[ST_CYCLE] = cycle_start;
		events[ST_CON] = con_hit;
		events[ST_FAULT] = fault_raw && !fault_prev;
		events[ST_WDOG] = wdog_expire;
		events[ST_DIV] = div_begin;
		w1c = (wr_pend && acc_addr == ADDR_STATUS) ? hwdata[ST_W-1:0] : '0;
		next_status = (status & ~w1c) | events;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			status <= '0;
			irq <= 1'b0;
		end
		else if (od)
		begin
			status <= '0;
			irq <= 1'b0;
		end
		else
		begin
			status <= next_status;
			irq <= |(next_status & mask);
		end
	end

	// Output enables drop while disabled; the test chain output has none and keeps driving.
	generate
		genvar gi;
		assign nand_chain[0] = pin_s2[PIN_NAND];
		for (gi = 1; gi < NAND_W; gi++)
		begin : g_chain
			assign nand_chain[gi] = !(nand_chain[gi-1] && pin_s2[PIN_NAND + gi]);
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pins_oe <= 1'b0;
			nand_chain_out <= 1'b0;
		end
		else
		begin
			pins_oe <= !od;
			nand_chain_out <= nand_chain[NAND_W-1];
		end
	end

endmodule

`default_nettype wire

// [sim/cto_properties.sv]
`default_nettype none
module cto_properties
	import cto_pkg::*;
#(
	parameter int NAND_W = 8,
	parameter int CLK_MHZ = MCLK_MHZ
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic rx_distortion_in,
	input wire logic rx_signal_absent_in,
	input wire logic output_disable_in,
	input wire logic [NAND_W-1:0] nand_chain_in,
	input wire logic control_pulse_out,
	input wire logic divided_pulse_out,
	input wire logic line_fault_n,
	input wire logic watchdog_out_n,
	input wire logic pins_oe,
	input wire logic nand_chain_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] run;
	logic [3:0] od_h;
	logic [3:0] cz_h;
	logic [2:0] wr_h;
	logic taken;
	assign taken = hsel && htrans[1] && hready;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Input histories absorb the pin synchronisers, whose latency is two or three cycles.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			od_h <= 4'h0;
			cz_h <= 4'h0;
			wr_h <= 3'h0;
		end
		else
		begin
			od_h <= {od_h[2:0], output_disable_in};
			cz_h <= {cz_h[2:0], rx_distortion_in || rx_signal_absent_in};
			wr_h <= {wr_h[1:0], taken && hwrite};
		end
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			run <= 16'h0000;
		else
			run <= divided_pulse_out ? run + 16'h0001 : 16'h0000;
	end
	disabled_outputs_off_a:
		assert property (output_disable_in [*6] |-> !pins_oe && !control_pulse_out
			&& !divided_pulse_out && line_fault_n && watchdog_out_n)
		else $error("outputs active while disabled");
	enabled_drives_a:
		assert property ((!output_disable_in) [*5] |-> pins_oe)
		else $error("pins not driven while enabled");
	nand_last_low_a:
		assert property ((!nand_chain_in[NAND_W-1]) [*4] |-> nand_chain_out)
		else $error("nand chain output wrong");
	fault_has_cause_a:
		assert property ($fell(line_fault_n) |-> cz_h != 4'h0)
		else $error("line fault without cause");
	wdog_low_holds_a:
		assert property (!watchdog_out_n && wr_h == 3'h0 && !(taken && hwrite)
			&& od_h == 4'h0 && !output_disable_in |=> !watchdog_out_n)
		else $error("watchdog output released without kick");
	div_pulse_width_a:
		assert property ($fell(divided_pulse_out) |-> run == 16'(CLK_MHZ * DIV_PULSE_NS / 1000))
		else $error("divided pulse width wrong");
	read_wait_a:
		assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	write_no_wait_a:
		assert property (taken && hwrite |=> hreadyout)
		else $error("write stalled");
	resp_okay_a:
		assert property (taken |=> !hresp [*2])
		else $error("error response");
	cover property ($rose(control_pulse_out));
	cover property ($rose(divided_pulse_out));
	cover property ($fell(watchdog_out_n));
	cover property ($fell(line_fault_n));
endmodule
`default_nettype wire

// [sim/cto_sync_source.sv]
`default_nettype none
module cto_sync_source
#(
	parameter int SYNC_HIGH = 8,
	parameter int SCLK_HALF = 5
)
(
	input wire logic hclk,
	input wire logic cyc_run,
	input wire logic [15:0] cyc_period,
	output logic cycle_sync_in,
	output logic serial_clk_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] pos = 16'h0000;
	logic [7:0] sc = 8'h00;
	initial
	begin
		cycle_sync_in = 1'b0;
		serial_clk_in = 1'b0;
	end
	// The cycle pulse is high for SYNC_HIGH cycles, so rising and falling edges sit a known
	// distance apart and the bench can tell which edge started a cycle.
	always @(posedge hclk)
	begin
		pos <= (!cyc_run || pos == cyc_period - 16'h0001) ? 16'h0000 : pos + 16'h0001;
		cycle_sync_in <= cyc_run && pos < 16'(SYNC_HIGH);
	end
	always @(posedge hclk)
	begin
		sc <= (sc == 8'(SCLK_HALF - 1)) ? 8'h00 : sc + 8'h01;
		if (sc == 8'(SCLK_HALF - 1))
			serial_clk_in <= !serial_clk_in;
	end
endmodule
`default_nettype wire

// [sim/cycle_timing_outputs_bench.sv]
`default_nettype none
module cycle_timing_outputs_bench
	import cto_pkg::*;
	;
	timeunit 1ns;
	timeprecision 100ps;
	logic hclk;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic cycle_sync_in;
	logic serial_clk_in;
	logic rx_distortion_in = 1'b0;
	logic rx_signal_absent_in = 1'b0;
	logic output_disable_in = 1'b0;
	logic [7:0] nand_chain_in = 8'h7F;
	logic control_pulse_out, divided_pulse_out, serial_clock_half_out, serial_clock_quarter_out;
	logic line_fault_n, watchdog_out_n, pins_oe, nand_chain_out, irq;
	logic cyc_run = 1'b0;
	logic [15:0] cyc_period = 16'h03E8;
	int bad_count = 0;
	int check_count = 0;
	int d[2];
	int n, w, s, h, q;
	cto_cycle_timing i_cto_cycle_timing (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cycle_sync_in,
		.serial_clk_in, .rx_distortion_in, .rx_signal_absent_in, .output_disable_in,
		.nand_chain_in, .control_pulse_out, .divided_pulse_out, .serial_clock_half_out,
		.serial_clock_quarter_out, .line_fault_n, .watchdog_out_n, .pins_oe, .nand_chain_out,
		.irq);
	cto_sync_source i_cto_sync_source (.hclk, .cyc_run, .cyc_period, .cycle_sync_in,
		.serial_clk_in);
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Entered just after a rising edge; returns just after the edge that ends the data phase.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] dat,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= dat;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] dat);
		logic [31:0] rd;
		xfer(1'b1, a, dat, rd);
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] rd;
		xfer(1'b0, a, 32'h00000000, rd);
		check(rd, exp, what);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge hclk);
	endtask
	task automatic sync_rise();
		while (cycle_sync_in !== 1'b0) @(posedge hclk);
		while (cycle_sync_in !== 1'b1) @(posedge hclk);
	endtask
	task automatic ctl_measure(input logic idle, output int dly, output int wid);
		dly = 0;
		wid = 0;
		sync_rise();
		for (; control_pulse_out === idle && dly < 2000; dly++) @(posedge hclk);
		for (; control_pulse_out !== idle && wid < 2000; wid++) @(posedge hclk);
	endtask
	task automatic div_window(input int k, output int rises, output int wid);
		logic last;
		rises = 0;
		wid = 0;
		sync_rise();
		last = divided_pulse_out;
		repeat (k * 1000)
		begin
			@(posedge hclk);
			rises += int'(divided_pulse_out === 1'b1 && last === 1'b0);
			wid += int'(divided_pulse_out === 1'b1);
			last = divided_pulse_out;
		end
	endtask
	task automatic sclk_count(output int ns, output int nh, output int nq);
		logic ls, lh, lq;
		ns = 0;
		nh = 0;
		nq = 0;
		{ls, lh, lq} = {serial_clk_in, serial_clock_half_out, serial_clock_quarter_out};
		repeat (400)
		begin
			@(posedge hclk);
			ns += int'(serial_clk_in !== ls);
			nh += int'(serial_clock_half_out !== lh);
			nq += int'(serial_clock_quarter_out !== lq);
			{ls, lh, lq} = {serial_clk_in, serial_clock_half_out, serial_clock_quarter_out};
		end
	endtask
	function automatic logic [31:0] near(input int v, input int ns, input int dv);
		return 32'(v * dv >= ns - dv && v * dv <= ns + dv);
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rreg(ADDR_CTRL, 32'h00000000, "ctrl");
		rreg(ADDR_WDOG_LOAD, 32'h00FFFFFF, "wdog load");
		rreg(ADDR_CYCLE_POS, 32'h000FFFFF, "cycle pos");
		rreg(8'h30, 32'h00000000, "unmapped");
		wreg(ADDR_MASK, 32'h0000001F);
		rreg(ADDR_MASK, 32'h0000001F, "mask");
		$display("test registers done");
		wreg(ADDR_CON_START, 32'h0000000A);
		wreg(ADDR_CON_WIDTH, 32'h00000005);
		cyc_run <= 1'b1;
		for (int m = 0; m < 2; m++)
		begin
			wreg(ADDR_CTRL, m ? 32'h00000003 : 32'h00000000);
			ctl_measure(m[0], d[m], w);
			check(w, 5, "control width");
		end
		check(d[1] - d[0], 8, "sync edge select");
		rreg(ADDR_STATUS, 32'h00000003, "status");
		check(irq, 1, "irq");
		$display("test cycle done");
		wreg(ADDR_CTRL, 32'h00000000);
		wreg(ADDR_DIV_START, 32'h00000014);
		wreg(ADDR_DIV_PERIOD, 32'h00000032);
		wreg(ADDR_DIV_COUNT, 32'h00000003);
		div_window(1, n, w);
		check(n, 3, "div pulses");
		check(w, 3 * MCLK_MHZ * DIV_PULSE_NS / 1000, "div width");
		wreg(ADDR_CTRL, 32'h00000040);
		wreg(ADDR_DIV_COUNT, 32'h00000002);
		div_window(4, n, w);
		check(n, 2, "div every n");
		cyc_run <= 1'b0;
		cyc(700);
		wreg(ADDR_DIV_COUNT, 32'h00000000);
		$display("test divided done");
		for (int m = 0; m < 2; m++)
		begin
			wreg(ADDR_CTRL, m ? 32'h00000008 : 32'h00000000);
			cyc(8);
			sclk_count(s, h, q);
			check(near(h, s, m ? 1 : 2), 1, "half clock");
			check(near(q, s, m ? 2 : 4), 1, "quarter clock");
		end
		$display("test serial done");
		for (int k = 0; k < 3; k++)
		begin
			wreg(ADDR_CTRL, k < 2 ? 32'h00000010 : 32'h00000000);
			rx_distortion_in <= k != 1;
			rx_signal_absent_in <= k == 1;
			cyc(8);
			check(line_fault_n, k == 2, "fault");
			rx_distortion_in <= 1'b0;
			rx_signal_absent_in <= 1'b0;
			cyc(8);
			check(line_fault_n, 1, "fault clear");
		end
		wreg(ADDR_STATUS, 32'h00000004);
		wreg(ADDR_CTRL, 32'h00000030);
		rx_distortion_in <= 1'b1;
		cyc(8);
		check(line_fault_n, 0, "fault hold set");
		rx_distortion_in <= 1'b0;
		cyc(8);
		check(line_fault_n, 0, "fault held");
		wreg(ADDR_STATUS, 32'h00000004);
		cyc(3);
		check(line_fault_n, 1, "fault released");
		$display("test fault done");
		wreg(ADDR_STATUS, 32'h0000001F);
		wreg(ADDR_WDOG_LOAD, 32'h00000032);
		wreg(ADDR_WDOG_KICK, 32'h00000000);
		cyc(30);
		check(watchdog_out_n, 1, "wdog early");
		cyc(40);
		check(watchdog_out_n, 0, "wdog expiry");
		check(irq, 1, "irq wdog");
		wreg(ADDR_MASK, 32'h00000000);
		cyc(3);
		check(irq, 0, "irq masked");
		wreg(ADDR_MASK, 32'h00000008);
		wreg(ADDR_STATUS, 32'h00000008);
		cyc(3);
		check(irq, 0, "irq cleared");
		rreg(ADDR_STATUS, 32'h00000000, "status cleared");
		wreg(ADDR_WDOG_KICK, 32'h00000000);
		cyc(3);
		check(watchdog_out_n, 1, "wdog kick");
		$display("test watchdog done");
		output_disable_in <= 1'b1;
		cyc(8);
		check(pins_oe, 0, "oe off");
		check(nand_chain_out, 1, "nand out");
		nand_chain_in <= 8'hFF;
		cyc(8);
		check(nand_chain_out, 0, "nand chain");
		nand_chain_in <= 8'h7F;
		wreg(ADDR_MASK, 32'h0000001F);
		rreg(ADDR_MASK, 32'h00000000, "mask disabled");
		output_disable_in <= 1'b0;
		cyc(8);
		check(pins_oe, 1, "oe on");
		rreg(ADDR_WDOG_LOAD, 32'h00FFFFFF, "wdog load cleared");
		$display("test disable done");
		tally_and_finish();
	end
	initial
	begin
		repeat (40000) @(posedge hclk);
		bad_count++;
		tally_and_finish();
	end
endmodule
bind cto_cycle_timing cto_properties #(.NAND_W(NAND_W), .CLK_MHZ(CLK_MHZ))
	i_cto_properties (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
		.rx_distortion_in, .rx_signal_absent_in, .output_disable_in, .nand_chain_in,
		.control_pulse_out, .divided_pulse_out, .line_fault_n, .watchdog_out_n, .pins_oe,
		.nand_chain_out);
`default_nettype wire
